//--- scd_pkg.sv
// constants, field layout and carrier types of the stepper control field decoder
// assumes an APB master with 32-bit data and one clock domain
`default_nettype none
package scd_pkg;

  // ==================================================
  // bus and register map
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] IDX_CR0 = 8'h01;
  localparam logic [7:0] IDX_CR1 = 8'h02;
  localparam logic [7:0] IDX_CR2 = 8'h03;
  localparam logic [7:0] IDX_CR3 = 8'h08;
  localparam logic [APB_AW-1:0] ADR_CR0 = {IDX_CR0[5:0], 2'b00};
  localparam logic [APB_AW-1:0] ADR_CR1 = {IDX_CR1[5:0], 2'b00};
  localparam logic [APB_AW-1:0] ADR_CR2 = {IDX_CR2[5:0], 2'b00};
  localparam logic [APB_AW-1:0] ADR_CR3 = {IDX_CR3[5:0], 2'b00};

  // ==================================================
  // writable bits and reset value
  localparam logic [7:0] MSK_CR0 = 8'hff;
  localparam logic [7:0] MSK_CR1 = 8'hcf;
  localparam logic [7:0] MSK_CR2 = 8'hf0;
  localparam logic [7:0] MSK_CR3 = 8'hf7;
  localparam logic [7:0] RST_VAL = 8'h00;

  // ==================================================
  // field positions
  localparam int unsigned CR0_STEP_LSB = 5;
  localparam int unsigned CR0_CUR_LSB  = 0;
  localparam int unsigned CR1_DIRCTL   = 7;
  localparam int unsigned CR1_EDGE     = 6;
  localparam int unsigned CR1_PWMDBL   = 3;
  localparam int unsigned CR1_JITTER   = 2;
  localparam int unsigned CR1_SLEW     = 0;
  localparam int unsigned CR2_DRVEN    = 7;
  localparam int unsigned CR2_SLEEP    = 6;
  localparam int unsigned CR2_GAIN     = 5;
  localparam int unsigned CR2_OPAQUE   = 4;
  localparam int unsigned CR3_MODE     = 6;
  localparam int unsigned CR3_MASK     = 4;
  localparam int unsigned CR3_DUTY     = 2;
  localparam int unsigned CR3_BRIDGE   = 0;

  // ==================================================
  // strobe lengths in pwm clock cycles
  localparam int unsigned STB_W = 5;
  localparam logic [STB_W-1:0] STB_C00 = 5'h04;
  localparam logic [STB_W-1:0] STB_C01 = 5'h08;
  localparam logic [STB_W-1:0] STB_C10 = 5'h0c;
  localparam logic [STB_W-1:0] STB_C11 = 5'h13;
  localparam logic [2:0] STEP_RESERVED = 3'h7;

  // ==================================================
  // types
  typedef enum logic [2:0] {
    STEP_32, STEP_16, STEP_8, STEP_4, STEP_HALF_COMP, STEP_HALF_UNCOMP, STEP_FULL
  } scd_step_e;

  typedef enum logic [1:0] {
    DUTY_DEFAULT, DUTY_MIN1, DUTY_MIN2, DUTY_MIN3
  } scd_min_duty_e;

  typedef struct packed {
    logic [7:0] cr0;
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] cr3;
  } scd_regs_s;

endpackage
`default_nettype wire

//--- scd_field_decode.sv
// APB register bank and field decoder of a micro-stepping bipolar driver
// assumes pins DIR, step and pwm clock are asynchronous; pwm start is local
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - direction is pin xor invert bit
// - edge bit selects rising or falling step
// - two-bit slew field picks slope
// - transparency bit: 0 transparent, 1 opaque
// - gain bit: 0 half, 1 quarter
// - frequency double bit and jitter bit
// - three-bit step mode decode
// - sleep bit enters sleep mode
// - driver enable bit gates outputs
// - mask time 4, 8, 12, 19 cycles
// - duty bit selects 86% or 75%
// - bridge time 00 gives 4, 10 gives 12
// - strobes count pwm clock cycles
// - fields readable, writable, reset to zero
// - new values apply after select released
module scd_field_decode #(
  parameter logic [scd_pkg::STB_W-1:0] BRIDGE_C01 = scd_pkg::STB_C01,
  parameter logic [scd_pkg::STB_W-1:0] BRIDGE_C11 = scd_pkg::STB_C11
) (
  input  wire logic                        CLOCK_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [scd_pkg::APB_AW-1:0]  PADDR_I,
  input  wire logic [31:0]                 PWDATA_I,
  output logic      [31:0]                 PRDATA_O,
  output logic                             PREADY_O,
  output logic                             PSLVERR_O,
  input  wire logic                        DIR_I,
  input  wire logic                        STEP_INPUT_I,
  input  wire logic                        PWM_CLK_I,
  input  wire logic                        PWM_START_I,
  output logic                             DIR_CCW_O,
  output logic                             STEP_ADV_O,
  output logic      [1:0]                  SLEW_SLOPE_SEL_O,
  output logic                             SPEED_LOAD_ANGLE_OUT_OPAQUE_O,
  output logic                             SPEED_LOAD_ANGLE_OUT_GAIN_QTR_O,
  output logic                             PWM_DOUBLE_O,
  output logic                             PWM_JITTER_O,
  output scd_pkg::scd_step_e               STEP_MODE_SEL_O,
  output logic      [4:0]                  CURRENT_SEL_O,
  output logic                             SLEEP_O,
  output logic                             DRV_EN_O,
  output scd_pkg::scd_min_duty_e           MIN_DUTY_MODE_O,
  output logic                             DUTY75_O,
  output logic                             MASK_TIME_ACT_O,
  output logic                             COMP_BRIDGE_ACT_O
);
  import scd_pkg::*;

  // ==================================================
  // strobe length decode
  function automatic logic [STB_W-1:0] stb_len(input logic [1:0] sel,
                                               input logic [STB_W-1:0] c01,
                                               input logic [STB_W-1:0] c11);
    logic [STB_W-1:0] len;
    len = STB_C00;
    case (sel)
      2'b00:   len = STB_C00;
      2'b01:   len = c01;
      2'b10:   len = STB_C10;
      default: len = c11;
    endcase
    return len;
  endfunction

  // ==================================================
  // reset release
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ==================================================
  // pin synchronisers
  logic [2:0] step_sy_r;
  logic [1:0] dir_sy_r;
  logic [2:0] pwm_sy_r;

  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_sy_r <= 3'h0;
      dir_sy_r  <= 2'h0;
      pwm_sy_r  <= 3'h0;
    end
    else
    begin
      step_sy_r <= {step_sy_r[1:0], STEP_INPUT_I};
      dir_sy_r  <= {dir_sy_r[0], DIR_I};
      pwm_sy_r  <= {pwm_sy_r[1:0], PWM_CLK_I};
    end
  end

  wire step_rise = step_sy_r[1] & ~step_sy_r[2];
  wire step_fall = ~step_sy_r[1] & step_sy_r[2];
  wire pwm_tick  = pwm_sy_r[1] & ~pwm_sy_r[2];

  // ==================================================
  // APB slave
  scd_regs_s shadow_r;
  scd_regs_s act_r;
  logic      pending_r;

  wire setup    = PSEL_I & ~PENABLE_I;
  wire access   = PSEL_I & PENABLE_I;
  wire hit_cr0  = (PADDR_I == ADR_CR0);
  wire hit_cr1  = (PADDR_I == ADR_CR1);
  wire hit_cr2  = (PADDR_I == ADR_CR2);
  wire hit_cr3  = (PADDR_I == ADR_CR3);
  wire hit      = hit_cr0 | hit_cr1 | hit_cr2 | hit_cr3;
  wire wr_take  = access & PWRITE_I & hit;
  wire commit   = pending_r & ~PSEL_I;
  wire [7:0] wb = PWDATA_I[7:0];

  wire [7:0] rd_byte = hit_cr0 ? act_r.cr0 :
                       hit_cr1 ? act_r.cr1 :
                       hit_cr2 ? act_r.cr2 :
                       hit_cr3 ? act_r.cr3 : 8'h00;

  wire [2:0] new_step_mode  = shadow_r.cr0[CR0_STEP_LSB +: 3];
  wire [2:0] kept_step_mode = (new_step_mode == STEP_RESERVED) ?
                              act_r.cr0[CR0_STEP_LSB +: 3] : new_step_mode;

  assign PREADY_O = 1'b1;

  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shadow_r  <= {4{RST_VAL}};
      pending_r <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      if (setup)
      begin
        PRDATA_O  <= {24'h00_0000, rd_byte};
        PSLVERR_O <= ~hit;
      end
      if (wr_take & hit_cr0)
        shadow_r.cr0 <= wb & MSK_CR0;
      if (wr_take & hit_cr1)
        shadow_r.cr1 <= wb & MSK_CR1;
      if (wr_take & hit_cr2)
        shadow_r.cr2 <= wb & MSK_CR2;
      if (wr_take & hit_cr3)
        shadow_r.cr3 <= wb & MSK_CR3;
      if (wr_take)
        pending_r <= 1'b1;
      else if (commit)
        pending_r <= 1'b0;
    end
  end

  // ==================================================
  // applied field values
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
      act_r <= {4{RST_VAL}};
    else if (commit)
    begin
      act_r     <= shadow_r;
      act_r.cr0 <= {kept_step_mode, shadow_r.cr0[CR0_STEP_LSB-1:0]};
    end
  end

  // ==================================================
  // decoded outputs
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      DIR_CCW_O                       <= 1'b0;
      STEP_ADV_O                      <= 1'b0;
      SLEW_SLOPE_SEL_O                <= 2'h0;
      SPEED_LOAD_ANGLE_OUT_OPAQUE_O   <= 1'b0;
      SPEED_LOAD_ANGLE_OUT_GAIN_QTR_O <= 1'b0;
      PWM_DOUBLE_O                    <= 1'b0;
      PWM_JITTER_O                    <= 1'b0;
      STEP_MODE_SEL_O                 <= STEP_32;
      CURRENT_SEL_O                   <= 5'h00;
      SLEEP_O                         <= 1'b0;
      DRV_EN_O                        <= 1'b0;
      MIN_DUTY_MODE_O                 <= DUTY_DEFAULT;
      DUTY75_O                        <= 1'b0;
    end
    else
    begin
      DIR_CCW_O  <= dir_sy_r[1] ^ act_r.cr1[CR1_DIRCTL];
      STEP_ADV_O <= act_r.cr1[CR1_EDGE] ? step_fall : step_rise;
      SLEW_SLOPE_SEL_O                <= act_r.cr1[CR1_SLEW +: 2];
      SPEED_LOAD_ANGLE_OUT_OPAQUE_O   <= act_r.cr2[CR2_OPAQUE];
      SPEED_LOAD_ANGLE_OUT_GAIN_QTR_O <= act_r.cr2[CR2_GAIN];
      PWM_DOUBLE_O                    <= act_r.cr1[CR1_PWMDBL];
      PWM_JITTER_O                    <= act_r.cr1[CR1_JITTER];
      STEP_MODE_SEL_O <= scd_step_e'(act_r.cr0[CR0_STEP_LSB +: 3]);
      CURRENT_SEL_O                   <= act_r.cr0[CR0_CUR_LSB +: 5];
      SLEEP_O                         <= act_r.cr2[CR2_SLEEP];
      DRV_EN_O                        <= act_r.cr2[CR2_DRVEN];
      MIN_DUTY_MODE_O <= scd_min_duty_e'(act_r.cr3[CR3_MODE +: 2]);
      DUTY75_O                        <= act_r.cr3[CR3_DUTY];
    end
  end

  // ==================================================
  // strobe timers, 0 = mask, 1 = bridge
  logic [STB_W-1:0] stb_len_w [2];
  logic [STB_W-1:0] stb_cnt_r [2];
  logic [1:0]       stb_act_r;

  assign stb_len_w[0] = stb_len(act_r.cr3[CR3_MASK +: 2], STB_C01, STB_C11);
  assign stb_len_w[1] = stb_len(act_r.cr3[CR3_BRIDGE +: 2], BRIDGE_C01, BRIDGE_C11);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_stb
      logic [STB_W-1:0] cnt_nxt;
      assign cnt_nxt = PWM_START_I ? stb_len_w[gi] :
                       (pwm_tick && stb_cnt_r[gi] != '0) ? stb_cnt_r[gi] - 1'b1 :
                       stb_cnt_r[gi];
      always_ff @(posedge CLOCK_I or negedge rst_n)
      begin
        if (!rst_n)
        begin
          stb_cnt_r[gi] <= '0;
          stb_act_r[gi] <= 1'b0;
        end
        else
        begin
          stb_cnt_r[gi] <= cnt_nxt;
          stb_act_r[gi] <= (cnt_nxt != '0);
        end
      end
    end
  endgenerate

  assign MASK_TIME_ACT_O   = stb_act_r[0];
  assign COMP_BRIDGE_ACT_O = stb_act_r[1];

  // ==================================================
  // checks
  sequence s_commit;
    pending_r && !PSEL_I;
  endsequence

  sequence s_rise_sel;
    step_rise && !act_r.cr1[CR1_EDGE];
  endsequence

  sequence s_fall_sel;
    step_fall && act_r.cr1[CR1_EDGE];
  endsequence

  AST_DIR: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    ##1 DIR_CCW_O == ($past(dir_sy_r[1]) != $past(act_r.cr1[CR1_DIRCTL])))
    else $error("direction does not follow pin and invert bit");

  AST_STEP: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    (s_rise_sel or s_fall_sel) |=> STEP_ADV_O)
    else $error("selected step edge gave no advance");

  AST_STEP_QUIET: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    !step_rise && !step_fall |=> !STEP_ADV_O)
    else $error("advance without a step edge");

  AST_SLEW: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_commit |=> ##1 SLEW_SLOPE_SEL_O == $past(shadow_r.cr1[CR1_SLEW +: 2], 2))
    else $error("slew select not taken from written field");

  AST_CTRL_BITS: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_commit |=> ##1 SLEEP_O == $past(shadow_r.cr2[CR2_SLEEP], 2)
      && DRV_EN_O == $past(shadow_r.cr2[CR2_DRVEN], 2))
    else $error("sleep or driver enable not applied");

  AST_STEP_HOLD: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    s_commit ##0 (new_step_mode == STEP_RESERVED) |=> $stable(act_r.cr0[CR0_STEP_LSB +: 3]))
    else $error("reserved step mode was applied");

  AST_HOLD_BUSY: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    PSEL_I |=> $stable(act_r))
    else $error("fields changed while select held");

  AST_RESET: assert property (@(posedge CLOCK_I)
    $rose(rst_n) |-> act_r == '0 && shadow_r == '0)
    else $error("fields not zero after reset");

  AST_MASK: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    PWM_START_I && act_r.cr3[CR3_MASK +: 2] == 2'b11 |=> stb_cnt_r[0] == STB_C11)
    else $error("mask length for code 11 wrong");

  AST_MASK_TICK: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
    !PWM_START_I && !pwm_tick |=> $stable(stb_cnt_r[0]))
    else $error("mask timer moved without a pwm clock edge");

endmodule // scd_field_decode
`default_nettype wire

//--- scd_mcu_model.sv
// pin-side model of the controlling microcontroller
// assumes the bench clock; drives direction, step and pwm clock pins
`timescale 1ns/10ps
`default_nettype none
module scd_mcu_model #(
  parameter int PWM_P = 6
) (
  input  wire logic clk_i,
  input  wire logic dir_i,
  input  wire logic step_i,
  output var  logic dir_o,
  output var  logic step_o,
  output var  logic pwm_clk_o
);
  int cnt = 0;
  // ==========
  // free-running pwm clock, pins follow the bench
  always @(posedge clk_i)
  begin
    cnt <= (cnt == PWM_P - 1) ? 0 : cnt + 1;
    pwm_clk_o <= (cnt < PWM_P / 2);
    dir_o <= dir_i;
    step_o <= step_i;
  end
endmodule // scd_mcu_model
`default_nettype wire

//--- testbench.sv
// self-checking bench of the control field decoder
// assumes the pin model file and the design package
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import scd_pkg::*;
  localparam int P = 6;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd;
  logic pready, perr, dir_q = 0, stp_q = 0, dir, stp, pclk, start = 0;
  logic dccw, sadv, opq, gqtr, dbl, jit, slp, drv, d75, mact, bact;
  logic [1:0] slew;
  logic [4:0] cur;
  logic [7:0] r;
  scd_step_e smode;
  scd_min_duty_e mdm;
  logic [7:0] m [4] = '{default: 8'h00};
  logic [7:0] adr [4] = '{ADR_CR0, ADR_CR1, ADR_CR2, ADR_CR3};
  logic [7:0] msk [4] = '{MSK_CR0, MSK_CR1, MSK_CR2, MSK_CR3};
  logic [32:0] expq [$];
  int n_errors = 0, checked = 0, nadv = 0, base, dm, db;
  int seed = 32'hd70f7208;
  int len [4] = '{4, 8, 12, 19};

  always #20 clk = ~clk;

  scd_field_decode dut_u (.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr), .DIR_I(dir),
    .STEP_INPUT_I(stp), .PWM_CLK_I(pclk), .PWM_START_I(start),
    .DIR_CCW_O(dccw), .STEP_ADV_O(sadv), .SLEW_SLOPE_SEL_O(slew),
    .SPEED_LOAD_ANGLE_OUT_OPAQUE_O(opq), .SPEED_LOAD_ANGLE_OUT_GAIN_QTR_O(gqtr),
    .PWM_DOUBLE_O(dbl), .PWM_JITTER_O(jit), .STEP_MODE_SEL_O(smode),
    .CURRENT_SEL_O(cur), .SLEEP_O(slp), .DRV_EN_O(drv), .MIN_DUTY_MODE_O(mdm),
    .DUTY75_O(d75), .MASK_TIME_ACT_O(mact), .COMP_BRIDGE_ACT_O(bact));

  scd_mcu_model #(.PWM_P(P)) mcu_u (.clk_i(clk), .dir_i(dir_q),
    .step_i(stp_q), .dir_o(dir), .step_o(stp), .pwm_clk_o(pclk));

  // ==========
  // compare, verdict and bus tasks
  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
  begin
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  end
  endtask

  task automatic results();
  begin
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  end
  endtask

  task automatic wr(input int k, input logic [7:0] d);
    logic [7:0] v;
  begin
    apb(1'b1, adr[k], d);
    v = d & msk[k];
    if (k == 0 && v[7:5] == 3'h7) v[7:5] = m[0][7:5];
    m[k] = v;
  end
  endtask

  task automatic rd(input int k);
  begin
    expq.push_back({1'b0, 24'h0, m[k]});
    apb(1'b0, adr[k], 8'h00);
  end
  endtask

  task automatic fld();
  begin
    repeat (4) @(posedge clk);
    cmp({13'h0, dir_q ^ m[1][7], m[1][1:0], m[2][4], m[2][5], m[1][3], m[1][2],
      m[0][7:5], m[0][4:0], m[2][6], m[2][7], m[3][7:6], m[3][2]},
      {13'h0, dccw, slew, opq, gqtr, dbl, jit, smode, cur, slp, drv, mdm,
      d75});
  end
  endtask

  // ==========
  // read result watcher and step counter
  always @(posedge clk)
    if (psel && pen && !pwr && pready === 1'b1)
      cmp(expq.pop_front(), {perr, prd});

  always @(posedge clk)
    if (sadv === 1'b1)
      nadv <= nadv + 1;

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    results();
  end

  // ==========
  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    fld();
    for (int k = 0; k < 4; k++) rd(k);
    expq.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h00, 8'h00);
    apb(1'b1, 8'h10, 8'hff);
    for (int i = 0; i < 16; i++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        r = 8'($random(seed));
        dir_q <= r[0];
        if (k == 0) r[7:5] = i[2:0];
        if (k == 1) r[1:0] = i[1:0];
        if (k == 3) r[7:6] = i[3:2];
        wr(k, r);
      end
      fld();
      for (int k = 0; k < 4; k++) rd(k);
    end
    for (int e = 0; e < 2; e++)
    begin
      wr(1, (e == 1) ? 8'h40 : 8'h00);
      base = nadv;
      stp_q <= 1'b1;
      repeat (8) @(posedge clk);
      cmp(33'(nadv - base), 33'(e == 0));
      stp_q <= 1'b0;
      repeat (8) @(posedge clk);
      cmp(33'(nadv - base), 33'd1);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(3, 8'(c * 17));
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      dm = 0;
      db = 0;
      repeat (P * 20 + 20)
      begin
        @(posedge clk);
        dm += int'(mact === 1'b1);
        db += int'(bact === 1'b1);
      end
      cmp(33'(dm > (len[c] - 1) * P - 2 && dm <= len[c] * P + 4), 33'd1);
      cmp(33'(db > (len[c] - 1) * P - 2 && db <= len[c] * P + 4), 33'd1);
    end
    results();
  end
endmodule // testbench
`default_nettype wire
